//--- logic/wfr_pkg.sv
// Summary of operation
// - With brake_on_overflow set, a watchdog overflow starts a braking event that latches and shows in status.
// - With brake_on_overflow clear, a watchdog fault takes the normal reaction and never starts braking.
// - fault_latch_enable chooses a held fault (1) or a fault that follows its condition (0).
// - regulator_restart_tries gives directly the number of restart attempts, zero to three.
// - regulator_restart_delay sets the wait before each restart to (code + 1) times 0.5 ms.
// - stalled_rotor_detect_enable switches the stalled-rotor watchdog on; when clear that path is idle.
// - stalled_rotor_timeout sets the stalled-rotor overflow period to (code + 1) seconds.
// - converter_watchdog_disable set turns the buck start-up watchdog off; clear leaves it active.
// - Bits 15:13 of the extension register read as zero and ignore writes.
// - Asynchronous reset clears the whole extension register to zero.
// - The main watchdog faults when its period, in 100 us steps, passes without a restart.
// - The logic regulator source of the main watchdog recovers by the restart tries and delay settings.
package wfr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [6:0] WDX_CFG_ADDR = 7'h16;
  localparam logic [15:0] WDX_CFG_RESET = 16'h0000;
  localparam logic [15:0] WDX_CFG_WMASK = 16'h1fff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = (TICK_US * 1000000) / CLK_PERIOD_PS;
  localparam int RESTART_STEP_US = 500;
  localparam int RESTART_STEP_TICKS = RESTART_STEP_US / TICK_US;
  localparam int STALL_STEP_S = 1;
  localparam int STALL_STEP_TICKS = (STALL_STEP_S * 1000000) / TICK_US;
  localparam int BUCK_STARTUP_TICKS = 100;
  localparam int TIMER_W = 17;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] reserved;
    logic converter_watchdog_disable;
    logic [2:0] stalled_rotor_timeout;
    logic stalled_rotor_detect_enable;
    logic [3:0] regulator_restart_delay;
    logic [1:0] regulator_restart_tries;
    logic fault_latch_enable;
    logic brake_on_overflow;
  } wfr_cfg_t;

  typedef struct packed {
    logic main_overflow;
    logic stall_overflow;
    logic buck_overflow;
    logic fault;
    logic brake;
  } wfr_status_t;

  typedef enum logic [2:0] {
    RS_IDLE = 3'h1,
    RS_WAIT = 3'h2,
    RS_SPENT = 3'h4
  } wfr_rs_state_t;

endpackage

//--- logic/wfr_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module wfr_prescaler #(
  parameter int DIV = 25000
) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_resetn,  // Async reset, active low
  output logic o_tick         // One-cycle pulse every DIV cycles
);

  localparam int CW = $clog2(DIV);
  logic [CW-1:0] count;

  if (DIV < 2)
  begin : g_chk
    $error("wfr_prescaler: DIV must be at least 2");
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      count <= '0;
      o_tick <= 1'b0;
    end
    else if (count == CW'(DIV - 1))
    begin
      count <= '0;
      o_tick <= 1'b1;
    end
    else
    begin
      count <= count + CW'(1);
      o_tick <= 1'b0;
    end
  end

endmodule // wfr_prescaler
`default_nettype wire

//--- logic/wfr_timeout.sv
`timescale 1ns/1ps
`default_nettype none
module wfr_timeout #(
  parameter int W = 17
) (
  input wire logic i_ref_clk,       // Clock
  input wire logic i_resetn,        // Async reset, active low
  input wire logic i_tick,          // Time base pulse
  input wire logic i_enable,        // Timer runs while high
  input wire logic i_kick,          // Restart from zero
  input wire logic [W-1:0] i_limit, // Ticks to overflow, at least 1
  output logic o_expired            // Level, held until kick or disable
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  if (W < 2)
  begin : g_chk
    $error("wfr_timeout: W must be at least 2");
  end

  assign next_count = count + W'(1);

  // Overflow sticks so a missed restart cannot be hidden by wrap-around
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      count <= '0;
      o_expired <= 1'b0;
    end
    else if (!i_enable || i_kick)
    begin
      count <= '0;
      o_expired <= 1'b0;
    end
    else if (i_tick && !o_expired)
    begin
      if (next_count >= i_limit)
        o_expired <= 1'b1;
      else
        count <= next_count;
    end
  end

endmodule // wfr_timeout
`default_nettype wire

//--- logic/wfr_watchdog_ext.sv
`timescale 1ns/1ps
`default_nettype none
module wfr_watchdog_ext #(
  parameter int TICK_CYCLES = wfr_pkg::TICK_CYCLES
) (
  input wire logic i_ref_clk,            // 250 MHz clock
  input wire logic i_resetn,             // Async reset, active low
  input wire logic i_reg_wr,             // Register write strobe
  input wire logic i_reg_rd,             // Register read strobe
  input wire logic [6:0] i_reg_addr,     // Register address
  input wire logic [15:0] i_reg_wdata,   // Write data
  output logic [15:0] o_reg_rdata,       // Read data, one cycle after read
  input wire logic i_wd_enable,          // Main watchdog enable
  input wire logic [9:0] i_wd_period,    // Main period code, 100 us steps
  input wire logic i_wd_kick,            // Restart from selected input
  input wire logic i_src_regulator,      // Selected input is logic regulator
  input wire logic i_rotor_kick,         // Rotor movement restart
  input wire logic i_buck_ready,         // Buck converter came up
  input wire logic i_fault_clear,        // Software clears fault status
  output wfr_pkg::wfr_cfg_t o_cfg,       // Extension settings
  output wfr_pkg::wfr_status_t o_status, // Fault and brake status
  output logic o_brake_start,            // Pulse when braking starts
  output logic o_regulator_restart       // Pulse per restart attempt
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wfr_pkg::wfr_cfg_t cfg;
  wfr_pkg::wfr_rs_state_t rs_state;
  wfr_pkg::wfr_rs_state_t next_rs_state;
  logic tick;
  logic main_exp;
  logic main_exp_d;
  logic stall_exp;
  logic buck_exp;
  logic delay_exp;
  logic buck_seen;
  logic reg_hit;
  logic fault_cond;
  logic reg_trigger;
  logic [1:0] tries_left;
  logic [wfr_pkg::TIMER_W-1:0] main_limit;
  logic [wfr_pkg::TIMER_W-1:0] stall_limit;
  logic [wfr_pkg::TIMER_W-1:0] delay_limit;

  if (TICK_CYCLES < 2)
  begin : g_chk
    $error("wfr_watchdog_ext: TICK_CYCLES must be at least 2");
  end

  function automatic logic [wfr_pkg::TIMER_W-1:0] code_to_ticks(
    input logic [9:0] code,
    input int step
  );
    logic [wfr_pkg::TIMER_W-1:0] n;
    n = wfr_pkg::TIMER_W'(code) + wfr_pkg::TIMER_W'(1);
    return wfr_pkg::TIMER_W'(n * wfr_pkg::TIMER_W'(step));
  endfunction

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  assign reg_hit = (i_reg_addr == wfr_pkg::WDX_CFG_ADDR);

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      cfg <= wfr_pkg::wfr_cfg_t'(wfr_pkg::WDX_CFG_RESET);
    else if (i_reg_wr && reg_hit)
      cfg <= wfr_pkg::wfr_cfg_t'(i_reg_wdata & wfr_pkg::WDX_CFG_WMASK);
  end

  // Unmapped reads return zero
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_reg_rdata <= '0;
    else if (i_reg_rd)
      o_reg_rdata <= reg_hit ? (16'(cfg) & wfr_pkg::WDX_CFG_WMASK) : 16'h0000;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_cfg <= wfr_pkg::wfr_cfg_t'(wfr_pkg::WDX_CFG_RESET);
    else
      o_cfg <= cfg;
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  assign main_limit = code_to_ticks(i_wd_period, 1);
  assign stall_limit = code_to_ticks(10'(cfg.stalled_rotor_timeout), wfr_pkg::STALL_STEP_TICKS);
  assign delay_limit = code_to_ticks(10'(cfg.regulator_restart_delay), wfr_pkg::RESTART_STEP_TICKS);

  wfr_prescaler #(.DIV(TICK_CYCLES)) u_tick (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .o_tick(tick)
  );

  // A restart attempt also restarts the main count
  wfr_timeout #(.W(wfr_pkg::TIMER_W)) u_main (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_tick(tick),
    .i_enable(i_wd_enable),
    .i_kick(i_wd_kick || o_regulator_restart),
    .i_limit(main_limit),
    .o_expired(main_exp)
  );

  wfr_timeout #(.W(wfr_pkg::TIMER_W)) u_stall (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_tick(tick),
    .i_enable(cfg.stalled_rotor_detect_enable),
    .i_kick(i_rotor_kick),
    .i_limit(stall_limit),
    .o_expired(stall_exp)
  );

  // Start-up watchdog stops for good once the buck reports ready
  wfr_timeout #(.W(wfr_pkg::TIMER_W)) u_buck (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_tick(tick),
    .i_enable(!buck_seen),
    .i_kick(1'b0),
    .i_limit(wfr_pkg::TIMER_W'(wfr_pkg::BUCK_STARTUP_TICKS)),
    .o_expired(buck_exp)
  );

  wfr_timeout #(.W(wfr_pkg::TIMER_W)) u_delay (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_tick(tick),
    .i_enable(rs_state == wfr_pkg::RS_WAIT),
    .i_kick(1'b0),
    .i_limit(delay_limit),
    .o_expired(delay_exp)
  );

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      buck_seen <= 1'b0;
    else if (i_buck_ready)
      buck_seen <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Regulator restart sequence
  // ----------------------------------------------------------------
  assign reg_trigger = main_exp && !main_exp_d && i_src_regulator;

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      main_exp_d <= 1'b0;
    else
      main_exp_d <= main_exp;
  end

  always_comb
  begin
    next_rs_state = rs_state;
    unique case (rs_state)
      wfr_pkg::RS_IDLE:
        if (reg_trigger)
          next_rs_state = (tries_left != 2'h0) ? wfr_pkg::RS_WAIT : wfr_pkg::RS_SPENT;
      wfr_pkg::RS_WAIT:
        if (delay_exp)
          next_rs_state = wfr_pkg::RS_IDLE;
      wfr_pkg::RS_SPENT:
        if (i_wd_kick)
          next_rs_state = wfr_pkg::RS_IDLE;
      default:
        next_rs_state = wfr_pkg::RS_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rs_state <= wfr_pkg::RS_IDLE;
    else
      rs_state <= next_rs_state;
  end

  // Tries refill on a write or on a watchdog kick outside the restart wait
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      tries_left <= 2'h0;
    else if (i_reg_wr && reg_hit)
      tries_left <= i_reg_wdata[3:2];
    else if (rs_state == wfr_pkg::RS_WAIT && delay_exp && tries_left != 2'h0)
      tries_left <= tries_left - 2'h1;
    else if (i_wd_kick && rs_state != wfr_pkg::RS_WAIT)
      tries_left <= cfg.regulator_restart_tries;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_regulator_restart <= 1'b0;
    else
      o_regulator_restart <= (rs_state == wfr_pkg::RS_WAIT) && delay_exp;
  end

  // ----------------------------------------------------------------
  // Fault and braking
  // ----------------------------------------------------------------
  assign fault_cond = main_exp || (stall_exp && cfg.stalled_rotor_detect_enable)
    || (buck_exp && !cfg.converter_watchdog_disable);

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_status.main_overflow <= 1'b0;
      o_status.stall_overflow <= 1'b0;
      o_status.buck_overflow <= 1'b0;
    end
    else
    begin
      o_status.main_overflow <= main_exp;
      o_status.stall_overflow <= stall_exp && cfg.stalled_rotor_detect_enable;
      o_status.buck_overflow <= buck_exp && !cfg.converter_watchdog_disable;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_status.fault <= 1'b0;
    else if (cfg.fault_latch_enable)
      o_status.fault <= fault_cond || (o_status.fault && !i_fault_clear);
    else
      o_status.fault <= fault_cond;
  end

  // Braking latches regardless of the fault latch setting
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_status.brake <= 1'b0;
      o_brake_start <= 1'b0;
    end
    else
    begin
      o_status.brake <= (cfg.brake_on_overflow && fault_cond) || (o_status.brake && !i_fault_clear);
      o_brake_start <= cfg.brake_on_overflow && fault_cond && !o_status.brake;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence restart_fire;
    o_regulator_restart ##1 !o_regulator_restart;
  endsequence

  sequence wait_entry;
    rs_state == wfr_pkg::RS_IDLE ##1 rs_state == wfr_pkg::RS_WAIT;
  endsequence

  brake_start_a: assert property (cfg.brake_on_overflow && fault_cond && !o_status.brake |=> o_brake_start && o_status.brake)
    else $error("braking did not start on overflow");
  no_brake_a: assert property (!cfg.brake_on_overflow && !o_status.brake |=> !o_status.brake && !o_brake_start)
    else $error("braking started while disabled");
  latch_hold_a: assert property (cfg.fault_latch_enable && o_status.fault && !i_fault_clear |=> o_status.fault)
    else $error("latched fault dropped");
  fault_follow_a: assert property (!cfg.fault_latch_enable |=> o_status.fault == $past(fault_cond))
    else $error("unlatched fault does not follow condition");
  tries_bound_a: assert property (wait_entry |-> $past(tries_left) != 2'h0)
    else $error("restart wait without tries left");
  restart_pulse_a: assert property (rs_state == wfr_pkg::RS_WAIT && delay_exp |=> restart_fire)
    else $error("restart pulse missing after delay");
  stall_idle_a: assert property (!cfg.stalled_rotor_detect_enable |=> !o_status.stall_overflow)
    else $error("stall path active while disabled");
  stall_cause_a: assert property ($rose(stall_exp) |-> $past(cfg.stalled_rotor_detect_enable && tick))
    else $error("stall overflow without enabled tick");
  buck_off_a: assert property (cfg.converter_watchdog_disable |=> !o_status.buck_overflow)
    else $error("buck fault while disabled");
  reserved_zero_a: assert property (o_reg_rdata[15:13] == 3'h0 && cfg.reserved == 3'h0)
    else $error("reserved bits not zero");
  reset_clear_a: assert property (@(posedge i_ref_clk) disable iff (1'b0) $rose(i_resetn) |-> 16'(cfg) == 16'h0000)
    else $error("register not cleared by reset");
  main_tick_a: assert property ($rose(main_exp) |-> $past(tick && i_wd_enable))
    else $error("main overflow off a tick");
  src_reg_a: assert property ($rose(rs_state == wfr_pkg::RS_WAIT) |-> $past(i_src_regulator))
    else $error("restart sequence for wrong source");

endmodule // wfr_watchdog_ext
`default_nettype wire

//--- tb/wfr_watchdog_ext_tb.sv
`timescale 1ns/1ps
`default_nettype none
module wfr_watchdog_ext_tb;

  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  localparam int TICKS = 4;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [6:0] i_reg_addr = 7'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic [15:0] o_reg_rdata;
  logic i_wd_enable = 1'b0;
  logic [9:0] i_wd_period = 10'h000;
  logic i_wd_kick = 1'b0;
  logic i_src_regulator = 1'b0;
  logic i_rotor_kick = 1'b0;
  logic i_buck_ready = 1'b0;
  logic i_fault_clear = 1'b0;
  wfr_pkg::wfr_cfg_t o_cfg;
  wfr_pkg::wfr_status_t o_status;
  logic o_brake_start;
  logic o_regulator_restart;
  int num_errors = 0;
  int num_checks = 0;
  int n_brake = 0;
  int n_restart = 0;
  int n;
  logic [15:0] rd;

  always #2 i_ref_clk = ~i_ref_clk;

  // Short tick so the one-second stall timer fits in the run
  wfr_watchdog_ext #(.TICK_CYCLES(TICKS)) i_dut (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .i_wd_enable(i_wd_enable),
    .i_wd_period(i_wd_period),
    .i_wd_kick(i_wd_kick),
    .i_src_regulator(i_src_regulator),
    .i_rotor_kick(i_rotor_kick),
    .i_buck_ready(i_buck_ready),
    .i_fault_clear(i_fault_clear),
    .o_cfg(o_cfg),
    .o_status(o_status),
    .o_brake_start(o_brake_start),
    .o_regulator_restart(o_regulator_restart)
  );

  always @(posedge i_ref_clk)
  begin
    if (o_brake_start === 1'b1) n_brake++;
    if (o_regulator_restart === 1'b1) n_restart++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic do_reset();
    i_resetn = 1'b0;
    cycles(6);
    i_resetn = 1'b1;
  endtask

  task automatic reg_write(input logic [6:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    #1 i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    cycles(1);
    i_reg_wr = 1'b0;
  endtask

  task automatic reg_read(input logic [6:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    #1 i_reg_rd = 1'b1;
    i_reg_addr = a;
    cycles(1);
    i_reg_rd = 1'b0;
    cycles(1);
    d = o_reg_rdata;
  endtask

  task automatic pulse_kick();
    @(posedge i_ref_clk);
    #1 i_wd_kick = 1'b1;
    cycles(1);
    i_wd_kick = 1'b0;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return o_status.main_overflow;
      1: return o_regulator_restart;
      default: return o_status.stall_overflow;
    endcase
  endfunction

  // Bounded wait; a run-out is reported as a mismatch
  task automatic wait_for(input int sel, input int lim, output int k);
    k = 0;
    while (pick(sel) !== 1'b1 && k < lim)
    begin
      cycles(1);
      k++;
    end
    if (k >= lim) check(16'h0000, 16'h0001);
  endtask

  task automatic in_range(input int k, input int lo, input int hi);
    check({15'h0000, (k >= lo && k <= hi)}, 16'h0001);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    reg_read(7'h16, rd);
    check(rd, 16'h0000);
    check(16'(o_cfg), 16'h0000);
    reg_write(7'h16, 16'hffff);
    reg_read(7'h16, rd);
    check(rd, 16'h1fff);
    check(16'(o_cfg), 16'h1fff);
    reg_write(7'h17, 16'h0000);
    reg_read(7'h16, rd);
    check(rd, 16'h1fff);
    reg_read(7'h17, rd);
    check(rd, 16'h0000);
    // Buck start-up watchdog: off when disabled, fires after 100 ticks otherwise
    cycles(450);
    check({15'h0000, o_status.buck_overflow}, 16'h0000);
    do_reset();
    cycles(450);
    check({15'h0000, o_status.buck_overflow}, 16'h0001);
    i_buck_ready = 1'b1;
    do_reset();
    // Main overflow, unlatched, no braking
    i_wd_period = 10'd5;
    i_wd_enable = 1'b1;
    pulse_kick();
    wait_for(0, 100, n);
    in_range(n, 6 * TICKS - 2, 6 * TICKS + 1);
    cycles(2);
    check({14'h0000, o_status.fault, o_status.brake}, 16'h0002);
    check(16'(n_brake), 16'h0000);
    pulse_kick();
    cycles(3);
    check({15'h0000, o_status.fault}, 16'h0000);
    // Latched fault survives the end of its cause
    reg_write(7'h16, 16'h0002);
    wait_for(0, 100, n);
    cycles(2);
    i_wd_enable = 1'b0;
    cycles(4);
    check({14'h0000, o_status.main_overflow, o_status.fault}, 16'h0001);
    i_fault_clear = 1'b1;
    cycles(1);
    i_fault_clear = 1'b0;
    cycles(3);
    check({15'h0000, o_status.fault}, 16'h0000);
    // Braking on overflow latches by itself
    // Tries are loaded here so a restart on the wrong source would show up
    reg_write(7'h16, 16'h000d);
    i_wd_enable = 1'b1;
    pulse_kick();
    wait_for(0, 100, n);
    cycles(2);
    i_wd_enable = 1'b0;
    cycles(4);
    check({15'h0000, o_status.brake}, 16'h0001);
    check(16'(n_brake), 16'h0001);
    i_fault_clear = 1'b1;
    cycles(1);
    i_fault_clear = 1'b0;
    cycles(3);
    check({15'h0000, o_status.brake}, 16'h0000);
    check(16'(n_restart), 16'h0000);
    // Regulator restart: every try count, delay code 1 is ten ticks
    i_src_regulator = 1'b1;
    i_wd_period = 10'd0;
    for (int t = 0; t < 4; t++)
    begin
      reg_write(7'h16, 16'h0010 | 16'(t << 2));
      // Enable after the first write of tries; later passes keep it on while the overflow is held, so no overflow races the write
      i_wd_enable = 1'b1;
      n_restart = 0;
      pulse_kick();
      if (t > 0)
      begin
        wait_for(1, 200, n);
        in_range(n, 10 * TICKS + 2, 11 * TICKS + 1);
      end
      cycles(300);
      check(16'(n_restart), 16'(t));
    end
    // Stalled-rotor timer: code 0 is one second, ten thousand ticks
    i_src_regulator = 1'b0;
    i_wd_enable = 1'b0;
    reg_write(7'h16, 16'h0100);
    @(posedge i_ref_clk);
    #1 i_rotor_kick = 1'b1;
    cycles(1);
    i_rotor_kick = 1'b0;
    wait_for(2, 10000 * TICKS + 200, n);
    in_range(n, 10000 * TICKS - 8, 10000 * TICKS + 8);
    reg_write(7'h16, 16'h0000);
    cycles(3);
    check({15'h0000, o_status.stall_overflow}, 16'h0000);
    close_out();
  end

  // Run needs about 42400 cycles; give it ample margin
  initial
  begin
    #240000;
    num_errors++;
    close_out();
  end

endmodule // wfr_watchdog_ext_tb
`default_nettype wire
